// *** lnms_cfg.svh ***
// Constants for the node mode sequencer: offsets, fields, resets, timing
`ifndef LNMS_CFG_SVH
`define LNMS_CFG_SVH

// ==========================================================
// Clock and timing
`define LNMS_CLK_KHZ 10000
`define LNMS_INACT_MS 250
`define LNMS_INACT_CYC (`LNMS_INACT_MS * `LNMS_CLK_KHZ)
`define LNMS_DWELL_US 50
`define LNMS_DWELL_CYC ((`LNMS_DWELL_US * `LNMS_CLK_KHZ + 999) / 1000)
`define LNMS_BWF_US 100
`define LNMS_BWF_CYC ((`LNMS_BWF_US * `LNMS_CLK_KHZ + 999) / 1000)
`define LNMS_UV_LIMIT 3'h4

// ==========================================================
// Counter widths
`define LNMS_TMR_W 22
`define LNMS_CNT_W 16

// ==========================================================
// Register offsets and fields
`define LNMS_ADDR_MODE 8'h0B
`define LNMS_ADDR_CFG 8'h10
`define LNMS_ADDR_STAT 8'h11
`define LNMS_MODE_HI 7
`define LNMS_MODE_LO 6
`define LNMS_FLD_STBY 2'h0
`define LNMS_FLD_SLEEP 2'h1
`define LNMS_FLD_NORM 2'h2
`define LNMS_CFG_FS_BIT 0
`define LNMS_RST_MODE 2'h0
`define LNMS_RST_FS_EN 1'h0

`endif

// *** lnms_pkg.sv ***
// Types for the node mode sequencer
`include "lnms_cfg.svh"

package lnms_pkg;

	typedef enum logic [2:0] {
		LNMS_ST_INIT,
		LNMS_ST_SLEEP,
		LNMS_ST_STBY,
		LNMS_ST_NORM,
		LNMS_ST_FAILSAFE,
		LNMS_ST_TSD_OFF
	} lnms_state_t;

	typedef struct packed {
		logic [`LNMS_CNT_W-1:0] dom_cnt;
		logic armed;
		logic qual;
		logic wk_prev;
		logic wk_valid;
		logic bus_wake;
		logic loc_wake;
	} lnms_filt_t;

	typedef struct packed {
		lnms_state_t st;
		logic serial;
		logic fs_en;
		logic [1:0] mode_fld;
		logic [`LNMS_TMR_W-1:0] tmr;
		logic en_prev;
		logic [`LNMS_CNT_W-1:0] en_cnt;
		logic uv_prev;
		logic [2:0] uv_cnt;
		logic wake_req;
		logic reg_on;
		logic [7:0] rdata;
	} lnms_seq_t;

endpackage

// *** lnms_wake_filt.sv ***
// Bus wake filter and wake terminal edge detector
`timescale 1ns/1ps
`include "lnms_cfg.svh"

module lnms_wake_filt import lnms_pkg::*; #(
	parameter int BWF_CYC = `LNMS_BWF_CYC
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic bus_arm_in,
	input wire logic local_arm_in,
	input wire logic bus_rx_in,
	input wire logic wake_in,
	output logic bus_wake_out,
	output logic local_wakeup_event_out
);

	localparam logic [`LNMS_CNT_W-1:0] DOM_LAST =
		`LNMS_CNT_W'(BWF_CYC - 1);

	initial begin
		if (BWF_CYC < 1 || BWF_CYC >= (1 << `LNMS_CNT_W)) begin
			$error("BWF_CYC out of range");
		end
	end

	lnms_filt_t s_ff;
	lnms_filt_t nxt_s;

	// ==========================================================
	// Next state
	always_comb begin
		nxt_s = s_ff;
		nxt_s.bus_wake = 1'b0;
		nxt_s.loc_wake = 1'b0;
		if (!bus_arm_in) begin
			nxt_s.armed = 1'b0;
			nxt_s.qual = 1'b0;
			nxt_s.dom_cnt = '0;
		end else if (bus_rx_in) begin
			// Rising edge after a qualified dominant fires the wake
			nxt_s.bus_wake = s_ff.qual; // see R11
			nxt_s.armed = 1'b1;
			nxt_s.qual = 1'b0;
			nxt_s.dom_cnt = '0;
		end else if (s_ff.armed) begin
			// Dominant must follow a recessive and last the filter time
			if (s_ff.dom_cnt >= DOM_LAST) begin
				nxt_s.qual = 1'b1; // see R11
			end else begin
				nxt_s.dom_cnt = s_ff.dom_cnt + 1'b1;
			end
		end
		nxt_s.wk_prev = wake_in;
		nxt_s.wk_valid = 1'b1;
		if (local_arm_in && s_ff.wk_valid && (wake_in != s_ff.wk_prev)) begin
			nxt_s.loc_wake = 1'b1; // see R13
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign bus_wake_out = s_ff.bus_wake;
	assign local_wakeup_event_out = s_ff.loc_wake;

endmodule

// *** lnms_seq.sv ***
// Operating-mode sequencer of a bus transceiver with regulator
// ==========================================================
// Notes on behaviour
// R1: Sleep is left on a filtered bus wake or long-held high enable.
// R2: A 250 ms timer runs under rail undervoltage; expiry returns to sleep; the code gives normal on high enable (pin) or failsafe if on.
// R3: Sleep on long-low enable in pin control, or mode write 01 serially.
// R4: Sleep turns off driver, termination, receiver; keeps weak pull-up.
// R5: Bus wake in sleep goes to standby with termination switched on.
// R6: Long-high enable in standby (pin control) enters normal, both paths.
// R7: After power-up enable is sampled: low gives standby, high normal.
// R8: Serial mode write 00 in normal moves to standby.
// R9: With failsafe on, overvoltage, thermal or four undervoltages: failsafe.
// R10: Failsafe exits to standby on wake once faults clear; else stays.
// R11: Bus wake needs falling edge, dominant for filter time, rising edge.
// R12: Enable held high beyond dwell time is a local wake from sleep.
// R13: Wake terminal raises a local wake on either edge.
// R14: Local wake works only in sleep and standby and enters standby; the code also arms it in failsafe.
// R15: After bus wake receive output is held low until normal mode.
// R16: Reset output is pulled low while the rail is undervoltage.
// R17: Pin control: undervoltage timer expiry picks mode from enable.
// R18: Serial control: undervoltage expiry gives sleep or failsafe.
// R19: Pin control overvoltage: sleep, recheck enable every 250 ms.
// R20: Serial control overvoltage gives failsafe if enabled, else sleep.
// R21: Regulator off below supply threshold, on again above recovery.
// R22: Host waits dwell plus settle time before trusting a new mode.
// R23: Normal on enable rise (pin) or mode write 10 (serial); the code waits for enable held high for the dwell time.
// R24: Thermal shutdown holds reset low and forces transmitter recessive.
// R25: Mode write 11 is ignored.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/1ps
`include "lnms_cfg.svh"

module lnms_seq import lnms_pkg::*; #(
	parameter int INACT_CYC = `LNMS_INACT_CYC,
	parameter int DWELL_CYC = `LNMS_DWELL_CYC,
	parameter int BWF_CYC = `LNMS_BWF_CYC
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ctrl_serial_in,
	input wire logic en_in,
	input wire logic txd_in,
	input wire logic wake_in,
	input wire logic bus_rx_in,
	input wire logic rail_undervoltage_in,
	input wire logic rail_overvoltage_in,
	input wire logic thermal_shutdown_event_in,
	input wire logic supply_undervoltage_in,
	input wire logic supply_recovery_level_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic rd_in,
	output logic [7:0] rdata_out,
	output logic [2:0] mode_out,
	output logic rxd_out,
	output logic rxd_oe_n_out,
	output logic bus_tx_out,
	output logic bus_drv_en_out,
	output logic term_en_out,
	output logic weak_pullup_out,
	output logic rx_en_out,
	output logic limp_out,
	output logic reg_en_out,
	output logic reset_output_low_out
);

	localparam logic [`LNMS_TMR_W-1:0] TMR_LAST =
		`LNMS_TMR_W'(INACT_CYC - 1);
	localparam logic [`LNMS_CNT_W-1:0] DWELL_LAST =
		`LNMS_CNT_W'(DWELL_CYC);

	initial begin
		if (INACT_CYC < 1 || INACT_CYC >= (1 << `LNMS_TMR_W)) begin
			$error("INACT_CYC out of range");
		end
		if (DWELL_CYC < 1 || DWELL_CYC >= (1 << `LNMS_CNT_W)) begin
			$error("DWELL_CYC out of range");
		end
	end

	// ==========================================================
	// Address decode
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		hit = (a == off);
	endfunction

	lnms_seq_t s_ff;
	lnms_seq_t nxt_s;
	logic bus_wake;
	logic loc_wake;
	logic bus_arm;
	logic loc_arm;
	logic pin_ctl;
	logic fs_act;
	logic en_long_hi;
	logic en_long_lo;
	logic tmr_run;
	logic tmr_exp;
	logic fault;
	logic uv_rise;
	logic wr_mode;
	logic [1:0] wfld;

	// ==========================================================
	// Wake detection
	assign bus_arm = (s_ff.st == LNMS_ST_SLEEP) ||
		(s_ff.st == LNMS_ST_FAILSAFE);
	assign loc_arm = (s_ff.st == LNMS_ST_SLEEP) ||
		(s_ff.st == LNMS_ST_STBY) ||
		(s_ff.st == LNMS_ST_FAILSAFE); // see R14

	lnms_wake_filt #(
		.BWF_CYC(BWF_CYC)
	) u_wake (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.bus_arm_in(bus_arm),
		.local_arm_in(loc_arm),
		.bus_rx_in(bus_rx_in),
		.wake_in(wake_in),
		.bus_wake_out(bus_wake),
		.local_wakeup_event_out(loc_wake)
	);

	// ==========================================================
	// Qualifiers
	assign pin_ctl = !s_ff.serial;
	assign fs_act = s_ff.serial && s_ff.fs_en;
	assign en_long_hi = s_ff.en_prev && (s_ff.en_cnt >= DWELL_LAST);
	assign en_long_lo = !s_ff.en_prev && (s_ff.en_cnt >= DWELL_LAST);
	assign fault = rail_overvoltage_in || thermal_shutdown_event_in ||
		rail_undervoltage_in;
	assign tmr_run = rail_undervoltage_in ||
		((s_ff.st == LNMS_ST_SLEEP) && rail_overvoltage_in && pin_ctl) ||
		((s_ff.st == LNMS_ST_FAILSAFE) && fault);
	assign tmr_exp = tmr_run && (s_ff.tmr == TMR_LAST);
	assign uv_rise = rail_undervoltage_in && !s_ff.uv_prev;
	assign wr_mode = wr_in && hit(addr_in, `LNMS_ADDR_MODE);
	assign wfld = wdata_in[`LNMS_MODE_HI:`LNMS_MODE_LO];

	// ==========================================================
	// Next state
	always_comb begin
		nxt_s = s_ff;

		// Enable dwell tracking
		nxt_s.en_prev = en_in;
		if (en_in != s_ff.en_prev) begin
			nxt_s.en_cnt = '0;
		end else if (s_ff.en_cnt < DWELL_LAST) begin
			nxt_s.en_cnt = s_ff.en_cnt + 1'b1;
		end

		// Inactivity timer
		if (!tmr_run || tmr_exp) begin
			nxt_s.tmr = '0;
		end else begin
			nxt_s.tmr = s_ff.tmr + 1'b1; // see R2
		end

		// Undervoltage event count
		nxt_s.uv_prev = rail_undervoltage_in;
		if (uv_rise && (s_ff.uv_cnt < `LNMS_UV_LIMIT)) begin
			nxt_s.uv_cnt = s_ff.uv_cnt + 1'b1; // see R9
		end

		// Regulator hysteresis
		if (supply_undervoltage_in) begin
			nxt_s.reg_on = 1'b0; // see R21
		end else if (supply_recovery_level_in) begin
			nxt_s.reg_on = 1'b1; // see R21
		end

		// Register writes
		if (wr_mode && (wfld != 2'h3)) begin
			nxt_s.mode_fld = wfld; // see R25
		end
		if (wr_in && hit(addr_in, `LNMS_ADDR_CFG)) begin
			nxt_s.fs_en = wdata_in[`LNMS_CFG_FS_BIT];
		end

		// Mode transitions
		if (s_ff.st == LNMS_ST_INIT) begin
			nxt_s.serial = ctrl_serial_in;
			nxt_s.st = en_in ? LNMS_ST_NORM : LNMS_ST_STBY; // see R7
		end else if (thermal_shutdown_event_in) begin
			nxt_s.st = fs_act ? LNMS_ST_FAILSAFE : LNMS_ST_TSD_OFF; // see R9
		end else if (rail_overvoltage_in &&
			(s_ff.st != LNMS_ST_SLEEP) &&
			(s_ff.st != LNMS_ST_FAILSAFE)) begin
			nxt_s.st = fs_act ? LNMS_ST_FAILSAFE :
				LNMS_ST_SLEEP; // see R19 R20
		end else if ((s_ff.uv_cnt >= `LNMS_UV_LIMIT) && fs_act &&
			(s_ff.st != LNMS_ST_FAILSAFE)) begin
			nxt_s.st = LNMS_ST_FAILSAFE; // see R9
			nxt_s.uv_cnt = '0;
		end else if (tmr_exp && (s_ff.st != LNMS_ST_FAILSAFE)) begin
			if (pin_ctl) begin
				nxt_s.st = en_in ? LNMS_ST_NORM : LNMS_ST_SLEEP; // see R17
			end else begin
				nxt_s.st = fs_act ? LNMS_ST_FAILSAFE :
					LNMS_ST_SLEEP; // see R18
			end
		end else begin
			case (s_ff.st)
				LNMS_ST_SLEEP: begin
					if (bus_wake) begin
						nxt_s.st = LNMS_ST_STBY; // see R1 R5
						nxt_s.wake_req = 1'b1; // see R15
					end else if (loc_wake) begin
						nxt_s.st = LNMS_ST_STBY; // see R14
					end else if (pin_ctl && en_long_hi &&
						!rail_overvoltage_in) begin
						nxt_s.st = LNMS_ST_NORM; // see R12 R19
					end
				end
				LNMS_ST_STBY: begin
					if (pin_ctl) begin
						if (en_long_hi) begin
							nxt_s.st = LNMS_ST_NORM; // see R6 R15
						end
					end else if (wr_mode) begin
						if (wfld == `LNMS_FLD_NORM) begin
							nxt_s.st = LNMS_ST_NORM; // see R23
						end else if (wfld == `LNMS_FLD_SLEEP) begin
							nxt_s.st = LNMS_ST_SLEEP; // see R3
						end
					end
				end
				LNMS_ST_NORM: begin
					if (pin_ctl) begin
						if (en_long_lo) begin
							nxt_s.st = LNMS_ST_SLEEP; // see R3
						end
					end else if (wr_mode) begin
						if (wfld == `LNMS_FLD_STBY) begin
							nxt_s.st = LNMS_ST_STBY; // see R8
						end else if (wfld == `LNMS_FLD_SLEEP) begin
							nxt_s.st = LNMS_ST_SLEEP; // see R3
						end
					end
				end
				LNMS_ST_FAILSAFE: begin
					if (!fault && (bus_wake || loc_wake)) begin
						nxt_s.st = LNMS_ST_STBY; // see R10
						nxt_s.uv_cnt = '0;
					end
				end
				LNMS_ST_TSD_OFF: begin
					nxt_s.st = LNMS_ST_STBY;
				end
				default: begin
					nxt_s.st = LNMS_ST_INIT;
				end
			endcase
		end

		// Wake request ends with normal mode
		if (nxt_s.st == LNMS_ST_NORM) begin
			nxt_s.wake_req = 1'b0; // see R15
		end

		// Read data, valid the cycle after the strobe
		nxt_s.rdata = 8'h00;
		if (rd_in) begin
			if (hit(addr_in, `LNMS_ADDR_MODE)) begin
				nxt_s.rdata = {s_ff.mode_fld, 3'h0, 3'(s_ff.st)};
			end else if (hit(addr_in, `LNMS_ADDR_CFG)) begin
				nxt_s.rdata = {7'h00, s_ff.fs_en};
			end else if (hit(addr_in, `LNMS_ADDR_STAT)) begin
				nxt_s.rdata = {thermal_shutdown_event_in,
					rail_overvoltage_in, rail_undervoltage_in,
					s_ff.wake_req, s_ff.serial, s_ff.uv_cnt};
			end
		end
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_in) begin
		if (!rstn_in) begin
			s_ff.st <= LNMS_ST_INIT;
			s_ff.serial <= 1'b0;
			s_ff.fs_en <= `LNMS_RST_FS_EN;
			s_ff.mode_fld <= `LNMS_RST_MODE;
			s_ff.tmr <= '0;
			s_ff.en_prev <= 1'b0;
			s_ff.en_cnt <= '0;
			s_ff.uv_prev <= 1'b0;
			s_ff.uv_cnt <= '0;
			s_ff.wake_req <= 1'b0;
			s_ff.reg_on <= 1'b1;
			s_ff.rdata <= 8'h00;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================================
	// Pin and path control
	always_comb begin
		bus_drv_en_out = 1'b0;
		term_en_out = 1'b0;
		weak_pullup_out = 1'b0;
		rx_en_out = 1'b0;
		limp_out = 1'b0;
		rxd_out = 1'b1;
		rxd_oe_n_out = 1'b1;
		case (s_ff.st)
			LNMS_ST_SLEEP: begin
				weak_pullup_out = 1'b1; // see R4
			end
			LNMS_ST_STBY: begin
				term_en_out = 1'b1; // see R5
				rxd_out = 1'b0; // see R15
				rxd_oe_n_out = 1'b0;
			end
			LNMS_ST_NORM: begin
				term_en_out = 1'b1;
				rx_en_out = 1'b1; // see R6
				bus_drv_en_out = !thermal_shutdown_event_in;
				rxd_out = bus_rx_in; // see R15
				rxd_oe_n_out = 1'b0;
			end
			LNMS_ST_FAILSAFE: begin
				weak_pullup_out = 1'b1;
				limp_out = 1'b1; // see R9
			end
			LNMS_ST_TSD_OFF: begin
				term_en_out = 1'b1;
			end
			default: begin
				rxd_out = 1'b1;
			end
		endcase
	end

	assign bus_tx_out = (s_ff.st == LNMS_ST_NORM) &&
		!thermal_shutdown_event_in ? txd_in : 1'b1; // see R24
	assign reset_output_low_out = rail_undervoltage_in ||
		thermal_shutdown_event_in; // see R16 see R24
	assign reg_en_out = s_ff.reg_on && !thermal_shutdown_event_in &&
		(s_ff.st != LNMS_ST_SLEEP) &&
		(s_ff.st != LNMS_ST_FAILSAFE); // see R21
	assign mode_out = 3'(s_ff.st);
	assign rdata_out = s_ff.rdata;

endmodule

// *** lnms_seq_monitor.sv ***
// Assertion checker bound to the node mode sequencer ports
`timescale 1ns/1ps
`include "lnms_cfg.svh"

module lnms_seq_monitor import lnms_pkg::*; #(
	parameter int DWELL_CYC = 4
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ctrl_serial_in,
	input wire logic en_in,
	input wire logic rail_undervoltage_in,
	input wire logic rail_overvoltage_in,
	input wire logic thermal_shutdown_event_in,
	input wire logic supply_undervoltage_in,
	input wire logic [7:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic wr_in,
	input wire logic [2:0] mode_out,
	input wire logic rxd_oe_n_out,
	input wire logic bus_drv_en_out,
	input wire logic term_en_out,
	input wire logic weak_pullup_out,
	input wire logic rx_en_out,
	input wire logic reg_en_out,
	input wire logic reset_output_low_out
);
	logic calm;
	logic mwr;
	logic [15:0] dwell_ff;

	// ==========================================================
	// Helper logic
	assign calm = !rail_undervoltage_in && !rail_overvoltage_in
		&& !thermal_shutdown_event_in;
	assign mwr = wr_in && addr_in == `LNMS_ADDR_MODE && ctrl_serial_in && calm;
	always_ff @(posedge clk_in) begin
		if (!rstn_in || mode_out != LNMS_ST_STBY || !en_in || ctrl_serial_in
			|| !calm) begin
			dwell_ff <= 16'h0000;
		end else begin
			dwell_ff <= dwell_ff + 16'h0001;
		end
	end

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);

	// ==========================================================
	// Assertions
	property p_uv_rst; rail_undervoltage_in |-> reset_output_low_out; endproperty
	a_uv_rst: assert property (p_uv_rst)
		else $error("reset output not low under rail undervoltage");
	property p_sleep; mode_out == LNMS_ST_SLEEP |-> !bus_drv_en_out
		&& !term_en_out && !rx_en_out && weak_pullup_out; endproperty
	a_sleep: assert property (p_sleep)
		else $error("sleep path enables wrong");
	property p_norm; mode_out == LNMS_ST_NORM |-> rx_en_out && !rxd_oe_n_out
		&& (bus_drv_en_out || thermal_shutdown_event_in); endproperty
	a_norm: assert property (p_norm)
		else $error("normal paths not enabled");
	property p_wr_norm; mwr && wdata_in[7:6] == 2'h2
		&& mode_out == LNMS_ST_STBY |=> mode_out == LNMS_ST_NORM; endproperty
	a_wr_norm: assert property (p_wr_norm)
		else $error("mode write 10 did not enter normal");
	property p_wr_stby; mwr && wdata_in[7:6] == 2'h0
		&& mode_out == LNMS_ST_NORM |=> mode_out == LNMS_ST_STBY; endproperty
	a_wr_stby: assert property (p_wr_stby)
		else $error("mode write 00 did not enter standby");
	property p_wr_ign; mwr && wdata_in[7:6] == 2'h3 && (mode_out ==
		LNMS_ST_NORM || mode_out == LNMS_ST_STBY) |=> $stable(mode_out);
	endproperty
	a_wr_ign: assert property (p_wr_ign)
		else $error("mode write 11 changed the mode");
	property p_dwell; dwell_ff < 16'(DWELL_CYC + 4); endproperty
	a_dwell: assert property (p_dwell)
		else $error("long high enable left standby too late");
	property p_ov; ctrl_serial_in && rail_overvoltage_in
		&& !thermal_shutdown_event_in && mode_out == LNMS_ST_NORM |-> ##[1:2]
		(mode_out == LNMS_ST_SLEEP || mode_out == LNMS_ST_FAILSAFE); endproperty
	a_ov: assert property (p_ov)
		else $error("overvoltage did not leave normal");
	property p_reg; supply_undervoltage_in [*2] |-> !reg_en_out; endproperty
	a_reg: assert property (p_reg)
		else $error("regulator on under supply undervoltage");
endmodule

bind lnms_seq lnms_seq_monitor #(.DWELL_CYC(DWELL_CYC)) i_mon (
	.clk_in, .rstn_in, .ctrl_serial_in, .en_in, .rail_undervoltage_in,
	.rail_overvoltage_in, .thermal_shutdown_event_in, .supply_undervoltage_in,
	.addr_in, .wdata_in, .wr_in, .mode_out, .rxd_oe_n_out, .bus_drv_en_out,
	.term_en_out, .weak_pullup_out, .rx_en_out, .reg_en_out,
	.reset_output_low_out);

// *** lnms_host_model.sv ***
// Host controller model: enable, transmit and register port
`timescale 1ns/1ps

module lnms_host_model (
	input wire logic clk_in,
	output logic en_out,
	output logic txd_out,
	output logic [7:0] addr_out,
	output logic [7:0] wdata_out,
	output logic wr_out,
	output logic rd_out
);
	initial begin
		en_out = 1'h0;
		txd_out = 1'h1;
		addr_out = 8'h00;
		wdata_out = 8'h00;
		wr_out = 1'h0;
		rd_out = 1'h0;
	end

	// ==========================================================
	// Pin and register access
	task automatic drive(input logic en, input logic txd);
		@(posedge clk_in);
		en_out <= en;
		txd_out <= txd;
	endtask

	// Released bus shows inverse values, never the last ones
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= wr;
		rd_out <= !wr;
		@(posedge clk_in);
		wr_out <= 1'h0;
		rd_out <= 1'h0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask
endmodule

// *** testbench.sv ***
// Self-checking testbench for the node mode sequencer
`timescale 1ns/1ps
`include "lnms_cfg.svh"

module testbench import lnms_pkg::*;;
	localparam int IC = 50, DC = 4, BC = 4;
	localparam int WK = 6, BUS = 5, UV = 4, OV = 3, TS = 2, SU = 1, SR = 0;
	logic clk_in = 1'h0;
	logic rstn = 1'h0;
	logic serial = 1'h0;
	logic [6:0] drv = 7'h61;
	logic en, txd, wr, rd, rd_pend = 1'h0;
	logic [7:0] addr, wdata, rdata;
	logic [2:0] mode_out, rxs;
	logic [3:0] paths;
	logic rxd_out, rxd_oe_n_out, bus_tx_out, bus_drv_en_out, term_en_out;
	logic weak_pullup_out, rx_en_out, limp_out, reg_en_out, rst_low;
	logic [15:0] exp_q[$];
	logic [15:0] e;
	logic [7:0] wd [5] = '{8'h80, 8'hC0, 8'h00, 8'hC0, 8'h40};
	lnms_state_t st [5] = '{LNMS_ST_NORM, LNMS_ST_NORM, LNMS_ST_STBY,
		LNMS_ST_STBY, LNMS_ST_SLEEP};
	logic [31:0] rnd = 32'hEDF8;
	int failures = 0, n_compared = 0, cyc = 0, i;

	always #50 clk_in = ~clk_in;
	assign paths = {bus_drv_en_out, term_en_out, rx_en_out, weak_pullup_out};
	assign rxs = {term_en_out, rxd_out, rxd_oe_n_out};

	lnms_seq #(.INACT_CYC(IC), .DWELL_CYC(DC), .BWF_CYC(BC)) i_dut (
		.clk_in(clk_in), .rstn_in(rstn), .ctrl_serial_in(serial),
		.en_in(en), .txd_in(txd), .wake_in(drv[WK]), .bus_rx_in(drv[BUS]),
		.rail_undervoltage_in(drv[UV]), .rail_overvoltage_in(drv[OV]),
		.thermal_shutdown_event_in(drv[TS]), .supply_undervoltage_in(drv[SU]),
		.supply_recovery_level_in(drv[SR]), .addr_in(addr), .wdata_in(wdata),
		.wr_in(wr), .rd_in(rd), .rdata_out(rdata), .mode_out(mode_out),
		.rxd_out(rxd_out), .rxd_oe_n_out(rxd_oe_n_out), .bus_tx_out(bus_tx_out),
		.bus_drv_en_out(bus_drv_en_out), .term_en_out(term_en_out),
		.weak_pullup_out(weak_pullup_out), .rx_en_out(rx_en_out),
		.limp_out(limp_out), .reg_en_out(reg_en_out),
		.reset_output_low_out(rst_low));

	lnms_host_model i_host (.clk_in(clk_in), .en_out(en), .txd_out(txd),
		.addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction

	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wcyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask

	task automatic put(input int k, input logic v);
		@(posedge clk_in);
		drv[k] <= v;
	endtask

	task automatic wait_mode(input logic [2:0] m, input int n);
		int k;
		@(negedge clk_in);
		for (k = 0; k < n && mode_out !== m; k++) @(negedge clk_in);
		check("mode", 8'(mode_out), 8'(m));
	endtask

	task automatic rd_exp(input logic [7:0] a, input logic [7:0] m,
		input logic [7:0] v);
		exp_q.push_back({m, v});
		i_host.access(1'h0, a, 8'h00);
	endtask

	task automatic stop_test();
		$display("compared %0d, mismatched %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ==========================================================
	// Read watcher and timeout
	always @(posedge clk_in) begin
		if (rd_pend) begin
			e = exp_q.pop_front();
			check("rdata", rdata & e[15:8], e[7:0]);
		end
		rd_pend <= rd;
		cyc++;
		if (cyc == 5000) begin
			failures++;
			stop_test();
		end
	end

	// ==========================================================
	// Pin control then serial control
	initial begin
		repeat (12) @(posedge clk_in);
		rstn <= 1'h1;
		wait_mode(LNMS_ST_STBY, 4);
		rd_exp(`LNMS_ADDR_MODE, 8'h07, 8'(LNMS_ST_STBY));
		i_host.drive(1'h1, 1'h1);
		wait_mode(LNMS_ST_NORM, DC + 8);
		for (i = 0; i < 8; i++) begin
			rnd = xs(rnd);
			i_host.drive(1'h1, rnd[1]);
			drv[BUS] <= rnd[0];
			wcyc(3);
			check("rxd", 8'(rxd_out), 8'(rnd[0]));
			check("bus_tx", 8'(bus_tx_out), 8'(rnd[1]));
		end
		put(BUS, 1'h1);
		i_host.drive(1'h0, 1'h1);
		wait_mode(LNMS_ST_SLEEP, DC + 8);
		check("paths", 8'(paths), 8'h01);
		put(BUS, 1'h0);
		wcyc(BC - 2);
		put(BUS, 1'h1);
		wcyc(4);
		check("short", 8'(mode_out), 8'(LNMS_ST_SLEEP));
		put(BUS, 1'h0);
		wcyc(BC + 2);
		put(BUS, 1'h1);
		wait_mode(LNMS_ST_STBY, 6);
		check("wake_req", 8'(rxs), 8'h04);
		wcyc(DC + 4);
		check("wake_hold", 8'(rxs), 8'h04);
		i_host.drive(1'h1, 1'h1);
		wait_mode(LNMS_ST_NORM, 2 * DC + 8);
		check("release", 8'(rxs), 8'h06);
		$display("test bus wake finished");
		for (i = 0; i < 2; i++) begin
			i_host.drive(1'h0, 1'h1);
			wait_mode(LNMS_ST_SLEEP, DC + 8);
			put(WK, !drv[WK]);
			wait_mode(LNMS_ST_STBY, 6);
			wcyc(DC + 4);
			check("stby_hold", 8'(rxs), 8'h04);
			i_host.drive(1'h1, 1'h1);
			wait_mode(LNMS_ST_NORM, DC + 8);
		end
		i_host.drive(1'h0, 1'h1);
		wait_mode(LNMS_ST_SLEEP, DC + 8);
		i_host.drive(1'h1, 1'h1);
		wait_mode(LNMS_ST_NORM, 2 * DC + 8);
		put(WK, !drv[WK]);
		wcyc(4);
		check("no_lwu", 8'(mode_out), 8'(LNMS_ST_NORM));
		$display("test local wake finished");
		put(OV, 1'h1);
		wait_mode(LNMS_ST_SLEEP, 4);
		wcyc(IC - 10);
		check("ov_hold", 8'(mode_out), 8'(LNMS_ST_SLEEP));
		wait_mode(LNMS_ST_NORM, IC + 20);
		put(OV, 1'h0);
		wait_mode(LNMS_ST_NORM, IC + 20);
		put(UV, 1'h1);
		wcyc(1);
		check("rst_low", 8'(rst_low), 8'h01);
		put(UV, 1'h0);
		wcyc(1);
		check("rst_rel", 8'(rst_low), 8'h00);
		i_host.drive(1'h1, 1'h0);
		put(TS, 1'h1);
		wait_mode(LNMS_ST_TSD_OFF, 4);
		check("tsd", 8'({bus_tx_out, rst_low}), 8'h03);
		put(TS, 1'h0);
		wait_mode(LNMS_ST_STBY, 4);
		i_host.drive(1'h1, 1'h1);
		wait_mode(LNMS_ST_NORM, DC + 8);
		put(SU, 1'h1);
		put(SR, 1'h0);
		wcyc(2);
		check("reg_off", 8'(reg_en_out), 8'h00);
		put(SU, 1'h0);
		wcyc(2);
		check("reg_hold", 8'(reg_en_out), 8'h00);
		put(SR, 1'h1);
		wcyc(2);
		check("reg_on", 8'(reg_en_out), 8'h01);
		$display("test pin faults finished");
		@(posedge clk_in);
		rstn <= 1'h0;
		serial <= 1'h1;
		i_host.drive(1'h0, 1'h1);
		@(posedge clk_in);
		rstn <= 1'h1;
		wait_mode(LNMS_ST_STBY, 4);
		for (i = 0; i < 5; i++) begin
			i_host.access(1'h1, `LNMS_ADDR_MODE, wd[i]);
			rd_exp(`LNMS_ADDR_MODE, 8'h07, 8'(st[i]));
		end
		rd_exp(8'h55, 8'hFF, 8'h00);
		rd_exp(`LNMS_ADDR_CFG, 8'hFF, 8'h00);
		i_host.access(1'h1, `LNMS_ADDR_CFG, 8'h01);
		rd_exp(`LNMS_ADDR_CFG, 8'h01, 8'h01);
		put(WK, !drv[WK]);
		wait_mode(LNMS_ST_STBY, 6);
		i_host.access(1'h1, `LNMS_ADDR_MODE, 8'h80);
		wait_mode(LNMS_ST_NORM, 4);
		put(OV, 1'h1);
		wait_mode(LNMS_ST_FAILSAFE, 4);
		check("limp", 8'(limp_out), 8'h01);
		put(OV, 1'h0);
		put(WK, !drv[WK]);
		wait_mode(LNMS_ST_STBY, 6);
		for (i = 0; i < 4; i++) begin
			check("uv_count", 8'(mode_out), 8'(LNMS_ST_STBY));
			put(UV, 1'h1);
			put(UV, 1'h0);
			wcyc(2);
		end
		wait_mode(LNMS_ST_FAILSAFE, 4);
		put(WK, !drv[WK]);
		wait_mode(LNMS_ST_STBY, 6);
		put(UV, 1'h1);
		wait_mode(LNMS_ST_FAILSAFE, IC + 10);
		put(UV, 1'h0);
		put(WK, !drv[WK]);
		wait_mode(LNMS_ST_STBY, 6);
		i_host.access(1'h1, `LNMS_ADDR_CFG, 8'h00);
		put(OV, 1'h1);
		wait_mode(LNMS_ST_SLEEP, 4);
		put(OV, 1'h0);
		$display("test serial control finished");
		wcyc(4);
		stop_test();
	end
endmodule
